// ===== verif/scan_measure_sequencer_test.sv
// Self-checking bench for the scan measure sequencer.
`default_nettype none
module scan_measure_sequencer_test import smq_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int D = 20;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic meas_start, range_select, adc_done, chan_closed, l0_oe_n, line1, gpio, l0_o, rsel;
   logic [6:0] lvl;
   logic data_available, busy;
   logic [7:0] paddr, chan_index;
   logic [7:0] last_ch = 8'hFF;
   logic [15:0] adc_data;
   logic [31:0] pwdata, prdata, r;
   int n_mismatch = 0, checked = 0, n_start = 0, n_range = 0, cyc = 0, last_t = 0;
   int n_l0 = 0, n_ref = 0;
   logic [7:0] po [6] = '{SMQ_OFS_TRIG, SMQ_OFS_COUNTS, SMQ_OFS_DELAY, SMQ_OFS_PACE,
      SMQ_OFS_PERIOD, SMQ_OFS_LIST};
   logic [31:0] pe [6] = '{32'h0, 32'h1, D, D, D, 32'h100};

   // Short preset times keep every pass to a few hundred cycles.
   smq_sequencer #(.PRESET_DELAY_CYC(D), .PRESET_PACE_CYC(D), .PRESET_PERIOD_CYC(D))
   u_smq_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .meas_start(meas_start), .range_select(range_select), .ref_select(rsel),
      .adc_done(adc_done), .adc_data(adc_data), .level_percent(lvl),
      .chan_index(chan_index), .chan_closed(chan_closed), .ext_trigger_line_0_i(1'b0),
      .ext_trigger_line_0_o(l0_o), .ext_trigger_line_0_oe_n(l0_oe_n), .ext_trigger_line_1(line1),
      .gpio_trigger(gpio), .data_available(data_available), .busy(busy));
   smq_adc_model u_smq_adc_model (.pclk(pclk), .presetn(presetn), .meas_start(meas_start),
      .adc_done(adc_done), .adc_data(adc_data));

   // Clock at 20 MHz.
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // One idle cycle leads each transfer, so psel is never assigned twice in one step.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         chk("pready wait", 1, 0);
         final_report();
      end
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_idle();
      int i;
      for (i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge pclk);
      if (i >= 3000) begin
         chk("busy wait", 0, 1);
         final_report();
      end
   endtask

   // Count starts, range and line 0 pulses; gaps count only within one channel of a run.
   always @(posedge pclk) begin
      cyc++;
      if (busy !== 1'b1) last_ch = 8'hFF;
      if (range_select === 1'b1) n_range++;
      if (l0_o === 1'b1) n_l0++;
      if (meas_start === 1'b1 && rsel === 1'b1) n_ref++;
      if (meas_start === 1'b1) begin
         if (chan_index === last_ch) chk("sample gap", D, cyc - last_t);
         last_ch = chan_index;
         last_t = cyc;
         n_start++;
      end
   end

   // Main sequence.
   initial begin
      {psel, penable, pwrite, line1, gpio, presetn} = '0;
      {paddr, pwdata, lvl} = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      foreach (po[k]) begin
         apb(1'b0, po[k], 32'h0);
         chk("preset word", pe[k], r);
      end
      apb(1'b0, 8'h24, 32'h0);
      chk("unmapped error", 1, err);
      $display("test presets done");
      apb(1'b1, SMQ_OFS_TRIG, 32'h880);
      apb(1'b1, SMQ_OFS_COUNTS, 32'h0002_0002);
      apb(1'b1, SMQ_OFS_LIST, 32'h101);
      chk("line0 oe_n", 0, l0_oe_n);
      apb(1'b1, SMQ_OFS_CTRL, 32'h1);
      apb(1'b0, SMQ_OFS_TRIG, 32'h0);
      chk("ribbon source", 32'h881, r);
      wait_idle();
      chk("reading count", 8, n_start);
      chk("range count", 8, n_range);
      chk("line0 pulses", 8, n_l0);
      chk("channel open", 0, chan_closed);
      chk("data available", 1, data_available);
      for (int k = 0; k < 8; k++) begin
         apb(1'b0, SMQ_OFS_DATA, 32'h0);
         chk("reading", 32'hA000 + k, r);
      end
      // The last pop lands at the edge the read returns on, so let it settle first.
      @(posedge pclk);
      chk("drained", 0, data_available);
      $display("test internal passes done");
      // Rising edge on line 1 while idle must not count; only the later fall starts the pass.
      line1 <= 1'b1;
      apb(1'b1, SMQ_OFS_TRIG, 32'h103C);
      apb(1'b1, SMQ_OFS_COUNTS, 32'h1);
      apb(1'b1, SMQ_OFS_LIST, 32'h100);
      chk("line0 oe_n", 1, l0_oe_n);
      apb(1'b1, SMQ_OFS_CTRL, 32'h1);
      repeat (40) @(posedge pclk);
      chk("reference only", 9, n_start);
      line1 <= 1'b0;
      repeat (5) @(posedge pclk);
      gpio <= 1'b1;
      repeat (2) @(posedge pclk);
      gpio <= 1'b0;
      repeat (30) @(posedge pclk);
      chk("early port edge", 9, n_start);
      gpio <= 1'b1;
      wait_idle();
      chk("port trigger", 10, n_start);
      gpio <= 1'b0;
      for (int k = 8; k < 10; k++) begin
         apb(1'b0, SMQ_OFS_DATA, 32'h0);
         chk("reference first", 32'hA000 + k, r);
      end
      chk("reference flag", 1, n_ref);
      $display("test edge triggers done");
      // The preset command must overwrite a changed reading count and delay while idle, but keep the repeat count.
      apb(1'b1, SMQ_OFS_DELAY, 32'h5);
      apb(1'b1, SMQ_OFS_COUNTS, 32'h0003_0005);
      apb(1'b1, SMQ_OFS_CTRL, 32'h2);
      apb(1'b0, SMQ_OFS_TRIG, 32'h0);
      chk("preset trig", 32'h1808, r);
      apb(1'b0, SMQ_OFS_COUNTS, 32'h0);
      chk("preset counts", 32'h0003_0001, r);
      apb(1'b0, SMQ_OFS_DELAY, 32'h0);
      chk("preset delay", D, r);
      $display("test preset command done");
      // Threshold scan source at 50 percent; a measure edge before the pass starts nothing.
      lvl <= 7'h31;
      apb(1'b1, SMQ_OFS_TRIG, 32'h0032_0022);
      apb(1'b1, SMQ_OFS_COUNTS, 32'h1);
      apb(1'b1, SMQ_OFS_CTRL, 32'h1);
      line1 <= 1'b1;
      repeat (30) @(posedge pclk);
      chk("below threshold", 10, n_start);
      lvl <= 7'h32;
      line1 <= 1'b0;
      repeat (30) @(posedge pclk);
      line1 <= 1'b1;
      wait_idle();
      chk("threshold pass", 11, n_start);
      $display("test threshold trigger done");
      final_report();
   end
endmodule // scan_measure_sequencer_test
`default_nettype wire

// ===== verif/smq_adc_model.sv
// Converter model that answers each start pulse with a numbered reading.
`default_nettype none
module smq_adc_model #(parameter int unsigned LAT = 3) (
   // Clock, reset and converter handshake.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic meas_start,
   output logic adc_done,
   output logic [15:0] adc_data
);
   timeunit 1ns;
   timeprecision 1ns;
   int unsigned cnt_q;
   logic [15:0] num_q;
   // Off the done cycle the data bus toggles, so a stale word never passes for a reading.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 0;
         num_q <= 16'hA000;
         adc_done <= 1'b0;
         adc_data <= 16'h0000;
      end else begin
         adc_done <= (cnt_q == 1);
         adc_data <= (cnt_q == 1) ? num_q : ~adc_data;
         num_q <= num_q + ((cnt_q == 1) ? 16'h0001 : 16'h0000);
         cnt_q <= meas_start ? LAT : ((cnt_q != 0) ? cnt_q - 1 : 0);
      end
   end
endmodule // smq_adc_model
`default_nettype wire

// ===== verilog/smq_pkg.sv
// Package of register map, field codes and timing constants for the scan measure sequencer.
`default_nettype none
package smq_pkg;
   // Register byte offsets on the APB bus.
   localparam logic [7:0] SMQ_OFS_CTRL = 8'h00;
   localparam logic [7:0] SMQ_OFS_TRIG = 8'h04;
   localparam logic [7:0] SMQ_OFS_DELAY = 8'h08;
   localparam logic [7:0] SMQ_OFS_PACE = 8'h0C;
   localparam logic [7:0] SMQ_OFS_PERIOD = 8'h10;
   localparam logic [7:0] SMQ_OFS_COUNTS = 8'h14;
   localparam logic [7:0] SMQ_OFS_LIST = 8'h18;
   localparam logic [7:0] SMQ_OFS_STATUS = 8'h1C;
   localparam logic [7:0] SMQ_OFS_DATA = 8'h20;
   // Control and status bit positions.
   localparam int SMQ_CTRL_RUN = 0;
   localparam int SMQ_CTRL_PRESET = 1;
   localparam int SMQ_STAT_OVF = 5;
   // Scan trigger source codes.
   localparam logic [2:0] SMQ_SSRC_HOLD = 3'h0;
   localparam logic [2:0] SMQ_SSRC_INT = 3'h1;
   localparam logic [2:0] SMQ_SSRC_MEAS = 3'h2;
   localparam logic [2:0] SMQ_SSRC_EXT_TRIGGER_LINE_0 = 3'h3;
   localparam logic [2:0] SMQ_SSRC_EXT_TRIGGER_LINE_1 = 3'h4;
   localparam logic [2:0] SMQ_SSRC_GPIO = 3'h5;
   localparam logic [2:0] SMQ_SSRC_SCAN = 3'h6;
   // Measure trigger source codes.
   localparam logic [1:0] SMQ_MSRC_INT = 2'h0;
   localparam logic [1:0] SMQ_MSRC_EXT_TRIGGER_LINE_0 = 2'h1;
   localparam logic [1:0] SMQ_MSRC_EXT_TRIGGER_LINE_1 = 2'h2;
   localparam logic [1:0] SMQ_MSRC_GPIO = 2'h3;
   // Preset values loaded by reset and by the preset command.
   localparam logic [15:0] SMQ_PRESET_RPC = 16'h0001;
   localparam logic [7:0] SMQ_PRESET_PRESCAN = 8'h01;
   localparam logic [7:0] SMQ_PRESET_POST_SCAN_COUNT = 8'h00;
   // Preset times in microseconds and the clock rate.
   localparam int unsigned SMQ_CLK_HZ = 20_000_000;
   localparam int unsigned SMQ_DELAY_US = 1000;
   localparam int unsigned SMQ_PACE_US = 1000;
   localparam int unsigned SMQ_PERIOD_US = 1000;
   localparam int unsigned SMQ_DELAY_CYC = SMQ_DELAY_US * (SMQ_CLK_HZ / 1_000_000);
   localparam int unsigned SMQ_PACE_CYC = SMQ_PACE_US * (SMQ_CLK_HZ / 1_000_000);
   localparam int unsigned SMQ_PERIOD_CYC = SMQ_PERIOD_US * (SMQ_CLK_HZ / 1_000_000);
   // Trigger configuration word, laid out as it appears on the bus.
   typedef struct packed {
      logic [8:0] rsvd1;
      logic [6:0] threshold_percent;
      logic [2:0] rsvd0;
      logic ref_en;
      logic ribbon;
      logic autorange_timing;
      logic avail_flag_mode;
      logic stop_trig_source;
      logic ext_line0_direction;
      logic meas_edge;
      logic [1:0] meas_source;
      logic scan_trig_edge;
      logic [2:0] scan_trig_source;
   } smq_trig_t;
   // Reading counts word.
   typedef struct packed {
      logic [15:0] scan_repeat_count;
      logic [15:0] readings_per_channel;
   } smq_counts_t;
   // Channel list and pre/post scan word.
   typedef struct packed {
      logic [7:0] rsvd;
      logic [7:0] post_scan_count;
      logic [7:0] prescan_count;
      logic [7:0] last_chan;
   } smq_list_t;
endpackage
`default_nettype wire

// ===== verilog/smq_sequencer.sv
// Scan measure sequencer with APB registers, trigger selection and reading buffer.
//
// Register access over APB and the register addresses were left to the implementer.
`default_nettype none
// How it works
// - A pass starts only on a hit from the chosen scan source; no reading.
// - Each reading starts on its own measure trigger once the pass runs.
// - Threshold, line 0, line 1 and port scan sources use a chosen edge.
// - The percent threshold forms a scan trigger only for the threshold source.
// - After each scan trigger the programmed delay runs before measuring opens.
// - Exactly the programmed readings, or one when zero is programmed, are taken per channel before moving on.
// - Internal measure triggers start readings one sample period apart.
// - External line or port measure triggers fire on a chosen edge.
// - A config bit makes line 0 a trigger output or a trigger input.
// - Every finished reading is pushed into the buffer for the host while it has room.
// - After a channel finishes, the next channel repeats the same sequence.
// - After the last channel's reading the channel opens and the pass ends.
// - No repeat count means one pass; else 1 to 65535 passes.
// - Every repeated pass waits for a fresh scan trigger.
// - Reference readings are taken and stored before channel readings.
// - Preset disables scan trigger and picks internal measure and stop sources.
// - Preset sets one reading per channel.
// - Preset sets scan delay and scan pacing to one millisecond.
// - Preset sets internal measure trigger spacing to one millisecond.
// - Preset sets one prescan and zero postscans.
// - In any-stored mode data available rises once the buffer holds a reading.
// - In after mode range selection follows the measure trigger.
// - With ribbon input, a run turns a disabled scan source into internal.
module smq_sequencer
   import smq_pkg::*;
#(
   parameter int unsigned DATA_W = 16,
   parameter int unsigned BUF_DEPTH = 8,
   parameter int unsigned PRESET_DELAY_CYC = SMQ_DELAY_CYC,
   parameter int unsigned PRESET_PACE_CYC = SMQ_PACE_CYC,
   parameter int unsigned PRESET_PERIOD_CYC = SMQ_PERIOD_CYC
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Converter.
   output logic meas_start,
   output logic range_select,
   output logic ref_select,
   input wire logic adc_done,
   input wire logic [DATA_W-1:0] adc_data,
   input wire logic [6:0] level_percent,
   // Channel multiplexer.
   output logic [7:0] chan_index,
   output logic chan_closed,
   // Trigger pins.
   input wire logic ext_trigger_line_0_i,
   output logic ext_trigger_line_0_o,
   output logic ext_trigger_line_0_oe_n,
   input wire logic ext_trigger_line_1,
   input wire logic gpio_trigger,
   // Status.
   output logic data_available,
   output logic busy
);
   localparam int PTR_W = $clog2(BUF_DEPTH);
   localparam logic [PTR_W:0] BUF_FULL = (PTR_W + 1)'(BUF_DEPTH);

   typedef enum logic [2:0] {ST_IDLE, ST_REF, ST_ARM, ST_DLY, ST_MWAIT, ST_CONV} smq_state_t;

   smq_state_t st_q, st_d;
   smq_trig_t trig_q, trig_d;
   smq_counts_t counts_q;
   smq_list_t list_q;
   logic [31:0] delay_q, pace_q, period_q, prdata_q, rd_mux;
   logic [31:0] dly_cnt_q, pace_cnt_q, per_cnt_q;
   logic [15:0] rd_cnt_q, scan_cnt_q, rpc_eff, scan_total;
   logic [7:0] chan_q;
   logic closed_q, meas_start_q, range_q, ext_trigger_line_0_o_q, done_q, ovf_q;
   logic ext_trigger_line_0_p_q, ext_trigger_line_1_p_q, gpio_p_q, above_p_q;
   logic [DATA_W-1:0] mem_q [BUF_DEPTH];
   logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
   logic [PTR_W:0] cnt_q;

   // Edge picker: rising when fall is low, falling when it is high.
   function automatic logic edge_hit(input logic cur, input logic prev, input logic fall);
      return fall ? (prev & ~cur) : (cur & ~prev);
   endfunction

   // Bus decode; the slave never inserts wait states.
   wire setup_ph = psel & ~penable;
   wire access_ph = psel & penable;
   wire addr_ok = (paddr[1:0] == 2'h0) && (paddr <= SMQ_OFS_DATA);
   wire wr_en = access_ph & pwrite & addr_ok;
   wire rd_en = access_ph & ~pwrite & addr_ok;
   wire wr_ctrl = wr_en && (paddr == SMQ_OFS_CTRL);
   wire run_cmd = wr_ctrl & pwdata[SMQ_CTRL_RUN] & (st_q == ST_IDLE);
   wire preset_cmd = wr_ctrl & pwdata[SMQ_CTRL_PRESET] & (st_q == ST_IDLE);
   wire ovf_clr = wr_en && (paddr == SMQ_OFS_STATUS) && pwdata[SMQ_STAT_OVF];
   assign pready = 1'b1;
   assign pslverr = access_ph & ~addr_ok;
   assign prdata = prdata_q;

   // Pin level events, sampled against the previous cycle.
   wire ext_trigger_line_0_in_mode = ~trig_q.ext_line0_direction;
   wire above = level_percent >= trig_q.threshold_percent;
   wire sedge = trig_q.scan_trig_edge;
   wire medge = trig_q.meas_edge;
   wire s_ext_trigger_line_0 = ext_trigger_line_0_in_mode & edge_hit(ext_trigger_line_0_i, ext_trigger_line_0_p_q, sedge);
   wire s_ext_trigger_line_1 = edge_hit(ext_trigger_line_1, ext_trigger_line_1_p_q, sedge);
   wire s_gpio = edge_hit(gpio_trigger, gpio_p_q, sedge);
   wire s_meas = edge_hit(above, above_p_q, sedge);
   wire s_int = pace_cnt_q == 32'h0000_0000;
   wire [2:0] ssrc = trig_q.scan_trig_source;
   wire scan_src_hit = (ssrc == SMQ_SSRC_INT || ssrc == SMQ_SSRC_SCAN) ? s_int :
                       (ssrc == SMQ_SSRC_MEAS) ? s_meas :
                       (ssrc == SMQ_SSRC_EXT_TRIGGER_LINE_0) ? s_ext_trigger_line_0 :
                       (ssrc == SMQ_SSRC_EXT_TRIGGER_LINE_1) ? s_ext_trigger_line_1 :
                       (ssrc == SMQ_SSRC_GPIO) ? s_gpio : 1'b0;
   // Only the armed state listens, so a trigger mid pass is dropped.
   wire scan_hit = (st_q == ST_ARM) & scan_src_hit;
   wire m_ext_trigger_line_0 = ext_trigger_line_0_in_mode & edge_hit(ext_trigger_line_0_i, ext_trigger_line_0_p_q, medge);
   wire m_ext_trigger_line_1 = edge_hit(ext_trigger_line_1, ext_trigger_line_1_p_q, medge);
   wire m_gpio = edge_hit(gpio_trigger, gpio_p_q, medge);
   wire [1:0] msrc = trig_q.meas_source;
   wire meas_src_hit = (msrc == SMQ_MSRC_INT) ? (per_cnt_q == 32'h0000_0000) :
                       (msrc == SMQ_MSRC_EXT_TRIGGER_LINE_0) ? m_ext_trigger_line_0 :
                       (msrc == SMQ_MSRC_EXT_TRIGGER_LINE_1) ? m_ext_trigger_line_1 : m_gpio;
   // Measure triggers count only while waiting, never in the delay.
   wire meas_hit = (st_q == ST_MWAIT) & meas_src_hit;

   // Sequence bookkeeping.
   assign rpc_eff = (counts_q.readings_per_channel == 16'h0000) ? 16'h0001 :
                    counts_q.readings_per_channel;
   assign scan_total = (counts_q.scan_repeat_count == 16'h0000) ? 16'h0001 :
                       counts_q.scan_repeat_count;
   wire conv_done = (st_q == ST_CONV) & adc_done;
   wire ref_done = (st_q == ST_REF) & adc_done;
   wire rd_last = rd_cnt_q == rpc_eff - 16'h0001;
   wire ch_last = chan_q == list_q.last_chan;
   wire pass_end = conv_done & rd_last & ch_last;
   wire scan_last = scan_cnt_q == scan_total - 16'h0001;
   wire ref_go = run_cmd & trig_q.ref_en;

   // Buffer control; a push into a full buffer is lost and flagged.
   wire buf_empty = cnt_q == '0;
   wire buf_full = cnt_q == BUF_FULL;
   wire push = (conv_done | ref_done) & ~buf_full;
   wire pop = rd_en && (paddr == SMQ_OFS_DATA) && ~buf_empty;
   wire lost = (conv_done | ref_done) & buf_full;
   assign data_available = ~buf_empty & (~trig_q.avail_flag_mode | done_q);
   assign busy = st_q != ST_IDLE;

   // Read mux for the setup phase capture.
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         SMQ_OFS_TRIG: rd_mux = trig_q;
         SMQ_OFS_DELAY: rd_mux = delay_q;
         SMQ_OFS_PACE: rd_mux = pace_q;
         SMQ_OFS_PERIOD: rd_mux = period_q;
         SMQ_OFS_COUNTS: rd_mux = counts_q;
         SMQ_OFS_LIST: rd_mux = list_q;
         SMQ_OFS_STATUS: rd_mux = {scan_cnt_q, chan_q, 2'h0, ovf_q, data_available, busy,
                                   3'(st_q)};
         SMQ_OFS_DATA: rd_mux = 32'(mem_q[rd_ptr_q]);
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Trigger word write value; reserved bits always read as zero.
   always_comb begin
      trig_d = smq_trig_t'(pwdata);
      trig_d.rsvd0 = '0;
      trig_d.rsvd1 = '0;
   end

   // Next state of the pass sequence.
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: if (run_cmd) begin
            st_d = trig_q.ref_en ? ST_REF : ST_ARM;
         end
         ST_REF: if (adc_done) begin
            st_d = ST_ARM;
         end
         ST_ARM: if (scan_hit) begin
            st_d = ST_DLY;
         end
         ST_DLY: if (dly_cnt_q == 32'h0000_0000) begin
            st_d = ST_MWAIT;
         end
         ST_MWAIT: if (meas_hit) begin
            st_d = ST_CONV;
         end
         ST_CONV: if (adc_done) begin
            // A finished channel moves on; the last one closes the pass.
            st_d = ~(rd_last & ch_last) ? ST_MWAIT :
                   scan_last ? ST_IDLE : ST_ARM;
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // State, bus read capture and pin history.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_IDLE;
         prdata_q <= 32'h0000_0000;
         {ext_trigger_line_0_p_q, ext_trigger_line_1_p_q, gpio_p_q, above_p_q} <= 4'h0;
      end else begin
         st_q <= st_d;
         if (setup_ph) begin
            prdata_q <= rd_mux;
         end
         {ext_trigger_line_0_p_q, ext_trigger_line_1_p_q, gpio_p_q, above_p_q} <=
            {ext_trigger_line_0_i, ext_trigger_line_1, gpio_trigger, above};
      end
   end

   // Configuration registers; reset and the preset command load the same preset values, but only the preset command sets ribbon.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_q <= '0;
         delay_q <= PRESET_DELAY_CYC;
         pace_q <= PRESET_PACE_CYC;
         period_q <= PRESET_PERIOD_CYC;
         counts_q <= '{scan_repeat_count: 16'h0000, readings_per_channel: SMQ_PRESET_RPC};
         list_q <= '{rsvd: 8'h00, post_scan_count: SMQ_PRESET_POST_SCAN_COUNT,
                     prescan_count: SMQ_PRESET_PRESCAN, last_chan: 8'h00};
      end else if (preset_cmd) begin
         trig_q.scan_trig_source <= SMQ_SSRC_HOLD;
         trig_q.meas_source <= SMQ_MSRC_INT;
         trig_q.stop_trig_source <= 1'b0;
         trig_q.avail_flag_mode <= 1'b0;
         trig_q.autorange_timing <= 1'b0;
         trig_q.ribbon <= 1'b1;
         counts_q.readings_per_channel <= SMQ_PRESET_RPC;
         delay_q <= PRESET_DELAY_CYC;
         pace_q <= PRESET_PACE_CYC;
         period_q <= PRESET_PERIOD_CYC;
         list_q.prescan_count <= SMQ_PRESET_PRESCAN;
         list_q.post_scan_count <= SMQ_PRESET_POST_SCAN_COUNT;
      end else if (run_cmd && trig_q.ribbon && ssrc == SMQ_SSRC_HOLD) begin
         trig_q.scan_trig_source <= SMQ_SSRC_INT;
      end else if (wr_en && st_q == ST_IDLE) begin
         // Settings are frozen during a run so a pass never changes shape midway.
         case (paddr)
            SMQ_OFS_TRIG: trig_q <= trig_d;
            SMQ_OFS_DELAY: delay_q <= pwdata;
            SMQ_OFS_PACE: pace_q <= pwdata;
            SMQ_OFS_PERIOD: period_q <= pwdata;
            SMQ_OFS_COUNTS: counts_q <= smq_counts_t'(pwdata);
            SMQ_OFS_LIST: list_q <= {8'h00, pwdata[23:0]};
            default: ;
         endcase
      end
   end

   // Delay, pacing and sample period counters.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly_cnt_q <= 32'h0000_0000;
         pace_cnt_q <= 32'h0000_0000;
         per_cnt_q <= 32'h0000_0000;
      end else begin
         if (scan_hit) begin
            dly_cnt_q <= delay_q;
         end else if (st_q == ST_DLY && dly_cnt_q != 32'h0000_0000) begin
            dly_cnt_q <= dly_cnt_q - 32'h0000_0001;
         end
         if (run_cmd) begin
            pace_cnt_q <= 32'h0000_0000;
         end else if (scan_hit) begin
            pace_cnt_q <= pace_q;
         end else if (pace_cnt_q != 32'h0000_0000) begin
            pace_cnt_q <= pace_cnt_q - 32'h0000_0001;
         end
         if (meas_hit) begin
            per_cnt_q <= period_q - 32'h0000_0001;
         end else if (st_q == ST_DLY) begin
            per_cnt_q <= 32'h0000_0000;
         end else if (per_cnt_q != 32'h0000_0000) begin
            per_cnt_q <= per_cnt_q - 32'h0000_0001;
         end
      end
   end

   // Channel, reading and pass counters.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_q <= 8'h00;
         closed_q <= 1'b0;
         rd_cnt_q <= 16'h0000;
         scan_cnt_q <= 16'h0000;
         done_q <= 1'b0;
      end else begin
         if (run_cmd) begin
            scan_cnt_q <= 16'h0000;
            done_q <= 1'b0;
         end
         if (scan_hit) begin
            chan_q <= 8'h00;
            closed_q <= 1'b1;
            rd_cnt_q <= 16'h0000;
         end else if (conv_done) begin
            rd_cnt_q <= rd_last ? 16'h0000 : rd_cnt_q + 16'h0001;
            if (rd_last && !ch_last) begin
               chan_q <= chan_q + 8'h01;
            end
            if (pass_end) begin
               closed_q <= 1'b0;
               scan_cnt_q <= scan_cnt_q + 16'h0001;
               done_q <= scan_last;
            end
         end
      end
   end

   // Converter strobes and the line 0 trigger output.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meas_start_q <= 1'b0;
         range_q <= 1'b0;
         ext_trigger_line_0_o_q <= 1'b0;
      end else begin
         meas_start_q <= meas_hit | ref_go;
         range_q <= trig_q.autorange_timing ? (st_d == ST_MWAIT && st_q != ST_MWAIT) :
                    meas_hit;
         ext_trigger_line_0_o_q <= trig_q.ext_line0_direction & meas_hit;
      end
   end
   assign meas_start = meas_start_q;
   assign range_select = range_q;
   assign ref_select = st_q == ST_REF;
   assign chan_index = chan_q;
   assign chan_closed = closed_q;
   assign ext_trigger_line_0_o = ext_trigger_line_0_o_q;
   assign ext_trigger_line_0_oe_n = ~trig_q.ext_line0_direction;

   // Reading buffer held in flip-flops; the overflow flag lets a new loss win over a clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q <= '0;
         ovf_q <= 1'b0;
      end else begin
         if (push) begin
            mem_q[wr_ptr_q] <= adc_data;
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         cnt_q <= cnt_q + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
         ovf_q <= lost | (ovf_q & ~ovf_clr);
      end
   end

   // Checks on the sequencing.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_armed_hit;
      st_q == ST_ARM && scan_hit;
   endsequence

   chk_start_needs_trig: assert property (meas_start_q |-> st_q == ST_CONV || st_q == ST_REF)
      else $error("reading started without a measure trigger");
   chk_delay_mute: assert property (st_q == ST_DLY |=> !meas_start_q)
      else $error("reading started during scan delay");
   chk_delay_load: assert property (s_armed_hit |=> st_q == ST_DLY && dly_cnt_q == delay_q)
      else $error("scan delay not loaded on scan trigger");
   chk_scan_ignored: assert property (st_q == ST_CONV && scan_src_hit && !adc_done |=>
                                      st_q == ST_CONV && $stable(chan_q))
      else $error("scan trigger disturbed running pass");
   chk_chan_hold: assert property (conv_done && !rd_last |=> $stable(chan_q))
      else $error("channel advanced before its readings finished");
   chk_chan_adv: assert property (conv_done && rd_last && !ch_last |=>
                                  chan_q == $past(chan_q) + 8'h01 && st_q == ST_MWAIT)
      else $error("channel did not advance");
   chk_pass_open: assert property (pass_end |=> !chan_closed && st_q != ST_CONV)
      else $error("last channel not opened at pass end");
   chk_scan_limit: assert property (busy |-> scan_cnt_q < scan_total)
      else $error("more passes than programmed");
   chk_buffer_push: assert property (push && !pop |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("reading not stored in buffer");
   chk_preset_vals: assert property (preset_cmd |=>
                                     trig_q.scan_trig_source == SMQ_SSRC_HOLD &&
                                     counts_q.readings_per_channel == SMQ_PRESET_RPC &&
                                     delay_q == PRESET_DELAY_CYC && period_q == PRESET_PERIOD_CYC)
      else $error("preset values not loaded");
   chk_avail_any: assert property (!trig_q.avail_flag_mode && !buf_empty |-> data_available)
      else $error("data available missing with stored reading");
   chk_ext_trigger_line_0_drive: assert property (meas_hit |=>
                                    ext_trigger_line_0_o == !ext_trigger_line_0_oe_n)
      else $error("line 0 trigger pulse does not follow its direction");
endmodule // smq_sequencer
`default_nettype wire
